// ---- tb/three_channel_pwm_timer_tb.sv ----
// ============================================================
// three_channel_pwm_timer_tb: self-checking bench for the three channel pwm timer
// assumes: wishbone answers one cycle after a request is taken; pins follow level one cycle late
`timescale 1ns/10ps

module three_channel_pwm_timer_tb;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic standby = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [pwm_timer_pkg::ADR_W-1:0] adr = '0;
  logic [31:0] dat = 32'h0;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat_o;
  logic ack_o;
  wire [2:0] pins;
  wire [2:0] oes;
  int err_total = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [31:0] exq[$];
  string exn[$];
  int divs[8] = '{2, 8, 32, 128, 256, 1024, 2048, 4096};

  three_channel_pwm_timer u_three_channel_pwm_timer (
    .clk(clk), .arst_n(arst_n), .standby(standby), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .dat_i(dat), .sel_i(sel), .dat_o(dat_o), .ack_o(ack_o),
    .channel_one_pin(pins[0]), .channel_one_pin_oe(oes[0]),
    .channel_two_pin(pins[1]), .channel_two_pin_oe(oes[1]),
    .channel_three_pin(pins[2]), .channel_three_pin_oe(oes[2])
  );

  // ==========================================================
  // clock, timeout and reporting
  // ==========================================================
  always #2.5 clk = ~clk;

  // cut a hang short well beyond the expected run length
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles > 80000) begin
      err_total = err_total + 1;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("errors %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons = comparisons + 1;
    if (got !== exp) begin
      err_total = err_total + 1;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  // read answers are matched against the oldest note
  always @(posedge clk) begin
    if (ack_o === 1'b1 && cyc === 1'b1 && we === 1'b0) begin
      if (exq.size() == 0) begin
        chk("unexpected read", 32'hffffffff, dat_o);
      end else begin
        chk(exn.pop_front(), exq.pop_front(), dat_o);
      end
    end
  end

  // ==========================================================
  // wishbone classic master
  // ==========================================================
  task automatic wb(input logic w, input logic [15:0] idx, input logic [7:0] d, input logic [3:0] s,
                    input logic [7:0] e);
    logic [31:0] rnd;
    rnd = $urandom();
    if (!w) begin
      exq.push_back({24'h0, e});
      exn.push_back($sformatf("reg %h", idx));
    end
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'h0};
    dat <= {rnd[23:0], d};
    sel <= s;
    @(posedge clk);
    while (ack_o !== 1'b1) @(posedge clk);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] idx, input logic [7:0] e);
    wb(1'b0, idx, 8'h00, 4'hf, e);
  endtask

  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    wb(1'b1, idx, d, 4'h1, 8'h00);
  endtask

  // wait for an active pulse, measure its length and optionally the gap after it
  task automatic meas(input int ch, input logic act, input bit full, output int hi, output int lo);
    hi = 0;
    lo = 0;
    @(posedge clk);
    while (!(pins[ch] === act && oes[ch] === 1'b1)) @(posedge clk);
    while (pins[ch] === act) begin
      hi++;
      @(posedge clk);
    end
    if (full) begin
      while (pins[ch] !== act) begin
        lo++;
        @(posedge clk);
      end
    end
  endtask

  // ==========================================================
  // main sequence
  // ==========================================================
  initial begin
    int hi, lo, cnt, ch, ex;
    logic pol;
    logic [7:0] b;
    logic [15:0] base;
    logic [7:0] duties[6];
    duties = '{8'h00, 8'h01, 8'h7d, 8'hf9, 8'hfa, 8'hff};
    void'($urandom(69));
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    // reset values of every register, then unmapped places
    for (int c = 0; c < 3; c++) begin
      base = 16'hffc0 + 16'(4 * c);
      rd(base, 8'h38);
      rd(base + 16'h1, 8'hff);
      rd(base + 16'h2, 8'h00);
      chk("oe after reset", 32'h0, {31'h0, oes[c]});
    end
    wr(16'hffc3, 8'h55);
    rd(16'hffc3, 8'h00);
    rd(16'h0000, 8'h00);
    // reserved bits read ones, byte lane 0 gates writes
    wb(1'b1, 16'hffc0, 8'h47, 4'h1, 8'h00);
    rd(16'hffc0, 8'h7f);
    wr(16'hffc0, 8'h00);
    rd(16'hffc0, 8'h38);
    wb(1'b1, 16'hffc1, 8'h12, 4'he, 8'h00);
    rd(16'hffc1, 8'hff);
    // duty factor over one full period at /2, every channel
    for (int i = 0; i < 6; i++) begin
      ch = i % 3;
      base = 16'hffc0 + 16'(4 * ch);
      pol = 1'($urandom());
      wr(base, {1'b0, pol, 6'h00});
      wr(base + 16'h1, duties[i]);
      rd(base + 16'h1, duties[i]);
      wr(base, {1'b1, pol, 6'h00});
      repeat (20) @(posedge clk);
      cnt = 0;
      repeat (500) begin
        @(posedge clk);
        if ((pins[ch] ^ pol) === 1'b1) cnt++;
      end
      ex = (duties[i] == 8'h00) ? 0 : (duties[i] >= 8'hfa) ? 500 : (duties[i] - 1) * 2;
      chk("high cycles", 32'(ex), 32'(cnt));
      chk("oe while running", 32'h1, {31'h0, oes[ch]});
    end
    // pulse and period at /2, duty 7d
    wr(16'hffc0, 8'h00);
    wr(16'hffc1, 8'h7d);
    wr(16'hffc0, 8'h80);
    meas(0, 1'b1, 1'b1, hi, lo);
    chk("pulse width", 32'd248, 32'(hi));
    chk("period", 32'd500, 32'(hi + lo));
    // double buffering while running
    b = 8'($urandom_range(2, 249));
    wr(16'hffc1, b);
    rd(16'hffc1, 8'h7d);
    repeat (520) @(posedge clk);
    rd(16'hffc1, b);
    // stopping clears the counter and releases the pin; counters also take writes while running, which this bench never makes
    wr(16'hffc0, 8'h40);
    rd(16'hffc2, 8'h00);
    repeat (3) @(posedge clk);
    chk("oe stopped", 32'h0, {31'h0, oes[0]});
    // every divider code: one tick of duty 2 lasts one source period
    for (int code = 0; code < 8; code++) begin
      ch = code % 3;
      base = 16'hffc0 + 16'(4 * ch);
      pol = 1'($urandom());
      wr(base, 8'h00);
      wr(base + 16'h1, 8'h02);
      wr(base, {1'b0, pol, 3'h0, 3'(code)});
      wr(base, {1'b1, pol, 3'h0, 3'(code)});
      meas(ch, ~pol, 1'b0, hi, lo);
      chk("tick length", 32'(divs[code]), 32'(hi));
      wr(base, 8'h00);
    end
    // standby returns a running channel to reset values
    wr(16'hffc5, 8'h33);
    wr(16'hffc4, 8'h43);
    wr(16'hffc4, 8'hc3);
    repeat (40) @(posedge clk);
    standby <= 1'b1;
    repeat (3) @(posedge clk);
    standby <= 1'b0;
    rd(16'hffc4, 8'h38);
    rd(16'hffc5, 8'hff);
    rd(16'hffc6, 8'h00);
    chk("oe after standby", 32'h0, {31'h0, oes[1]});
    repeat (3) @(posedge clk);
    end_sim();
  end
endmodule

// ---- verilog/pwm_timer_pkg.sv ----
// ============================================================
// pwm_timer_pkg: constants and types of the three channel pwm timer
// ============================================================
// assumes: one system clock; registers reached over classic wishbone,
// byte address = 4 * register index, data in the low 8 bits.
package pwm_timer_pkg;

  // ==========================================================
  // geometry
  // ==========================================================
  localparam int NUM_CHANNELS = 3;
  localparam int COUNT_W = 8;
  localparam int PRESCALE_W = 12;
  localparam int ADR_W = 18;

  // ==========================================================
  // register indices (byte address is four times the index)
  // ==========================================================
  localparam logic [15:0] CH1_CONTROL_IDX = 16'hffc0;
  localparam logic [15:0] CH1_DUTY_IDX = 16'hffc1;
  localparam logic [15:0] CH1_COUNT_IDX = 16'hffc2;
  localparam logic [15:0] CH2_CONTROL_IDX = 16'hffc4;
  localparam logic [15:0] CH2_DUTY_IDX = 16'hffc5;
  localparam logic [15:0] CH2_COUNT_IDX = 16'hffc6;
  localparam logic [15:0] CH3_CONTROL_IDX = 16'hffc8;
  localparam logic [15:0] CH3_DUTY_IDX = 16'hffc9;
  localparam logic [15:0] CH3_COUNT_IDX = 16'hffca;
  // channels sit on a stride of four indices, registers within
  localparam logic [1:0] REG_CONTROL = 2'h0;
  localparam logic [1:0] REG_DUTY = 2'h1;
  localparam logic [1:0] REG_COUNT = 2'h2;

  // ==========================================================
  // values after reset and counting figures
  // ==========================================================
  localparam logic [7:0] CONTROL_RESET = 8'h38;
  localparam logic [7:0] DUTY_RESET = 8'hff;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] COUNT_TOP = 8'hf9;
  localparam logic [7:0] COUNT_ONE = 8'h01;
  localparam logic [7:0] DUTY_ZERO = 8'h00;
  localparam logic [7:0] DUTY_FULL = 8'hfa;
  localparam logic [2:0] RESERVED_ONES = 3'h7;

  // log2 of the divider for codes 0..7: /2 /8 /32 /128 /256 /1024 /2048 /4096
  localparam logic [7:0][3:0] DIV_LOG2 = {4'hc, 4'hb, 4'ha, 4'h8, 4'h7, 4'h5, 4'h3, 4'h1};

  // ==========================================================
  // types
  // ==========================================================
  typedef struct packed {
    logic run;
    logic polarity_select;
    logic [2:0] reserved;
    logic [2:0] divider_select;
  } channel_control_t;

  typedef struct packed {
    logic valid;
    logic [1:0] channel;
    logic [1:0] kind;
  } reg_decode_t;

endpackage

// ---- verilog/three_channel_pwm_timer.sv ----
// ============================================================
// three_channel_pwm_timer: three pwm channels behind a wishbone slave
// ============================================================
// assumes: classic wishbone master on clk; standby is a level from logic on clk;
// the pad logic muxes each pin to its port function while its _oe is low.
//
// Notes on behaviour
// - three identical channels, own counter, own pin
// - running counter counts 00 to f9, repeats
// - counter zero on reset and standby
// - duty steps of 1/250, 0..250
// - output set when count steps 0 to 1
// - output cleared when count reaches duty
// - active duty zero holds output low
// - running duty writes apply after f9 wrap
// - stopped duty writes apply at once
// - duty read returns active value
// - duty all ones on reset and standby
// - control reset pattern on reset, standby
// - run bit gates output and counter
// - polarity bit inverts pin level
// - control bits 5..3 read ones, ignore writes
// - divider codes give /2 to /4096
// - active duty 250..255 holds output high
// - pin undriven while run bit clear
//
// The Wishbone slave port is this design's own decision.
`timescale 1ns/10ps

module three_channel_pwm_timer #(
  parameter int NCH = pwm_timer_pkg::NUM_CHANNELS
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic standby,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [pwm_timer_pkg::ADR_W-1:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [3:0] sel_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic channel_one_pin,
  output logic channel_one_pin_oe,
  output logic channel_two_pin,
  output logic channel_two_pin_oe,
  output logic channel_three_pin,
  output logic channel_three_pin_oe
);

  // ==========================================================
  // helper functions
  // ==========================================================
  // maps a register index onto channel and register kind
  function automatic pwm_timer_pkg::reg_decode_t decode(input logic [15:0] idx);
    pwm_timer_pkg::reg_decode_t d;
    logic [15:0] rel;
    d = '0;
    rel = idx - pwm_timer_pkg::CH1_CONTROL_IDX;
    if (idx < pwm_timer_pkg::CH1_CONTROL_IDX) begin
      d.valid = 1'b0;
    end else if (rel[15:4] != 12'h000) begin
      d.valid = 1'b0;
    end else if (rel[3:2] >= 2'(NCH) || rel[1:0] == 2'h3) begin
      d.valid = 1'b0;
    end else begin
      d.valid = 1'b1;
      d.channel = rel[3:2];
      d.kind = rel[1:0];
    end
    return d;
  endfunction

  // one-cycle tick when the prescaler finishes a period of the chosen source
  function automatic logic source_tick(input logic [2:0] code,
                                       input logic [pwm_timer_pkg::PRESCALE_W-1:0] pre);
    logic [pwm_timer_pkg::PRESCALE_W-1:0] mask;
    mask = (pwm_timer_pkg::PRESCALE_W'(1) << pwm_timer_pkg::DIV_LOG2[code]) - pwm_timer_pkg::PRESCALE_W'(1);
    return (pre & mask) == mask;
  endfunction

  // ==========================================================
  // bus decode
  // ==========================================================
  pwm_timer_pkg::reg_decode_t dec;
  logic req;
  logic wr;
  logic [31:0] dat_q;
  logic [31:0] dat_d;
  logic ack_q;

  assign dec = decode(adr_i[pwm_timer_pkg::ADR_W-1:2]);
  assign req = cyc_i && stb_i && !ack_q;
  // writes land in the low byte only, at the edge where the master samples ack;
  // address and data are still held there, and a write is never applied
  // twice because ack is high for one cycle only
  assign wr = cyc_i && stb_i && ack_q && we_i && sel_i[0] && dec.valid;

  // ==========================================================
  // shared prescaler
  // ==========================================================
  logic [pwm_timer_pkg::PRESCALE_W-1:0] pre_q;

  // free-running divider feeding all eight sources
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pre_q <= '0;
    end else begin
      pre_q <= pre_q + pwm_timer_pkg::PRESCALE_W'(1);
    end
  end

  // ==========================================================
  // channels
  // ==========================================================
  pwm_timer_pkg::channel_control_t ctrl_q [NCH];
  logic [7:0] act_q [NCH];
  logic [7:0] buf_q [NCH];
  logic [7:0] cnt_q [NCH];
  logic [7:0] cnt_nxt [NCH];
  logic lvl_q [NCH];
  logic pin_q [NCH];
  logic oe_q [NCH];
  logic tick [NCH];
  logic wrap [NCH];

  // three identical channel slices
  for (genvar i = 0; i < NCH; i++) begin : g_ch
    logic sel_ch;
    logic wr_ctrl;
    logic wr_duty;
    logic wr_cnt;

    assign sel_ch = dec.channel == 2'(i);
    assign wr_ctrl = wr && sel_ch && dec.kind == pwm_timer_pkg::REG_CONTROL;
    assign wr_duty = wr && sel_ch && dec.kind == pwm_timer_pkg::REG_DUTY;
    assign wr_cnt = wr && sel_ch && dec.kind == pwm_timer_pkg::REG_COUNT;
    // divider code selects the source
    assign tick[i] = source_tick(ctrl_q[i].divider_select, pre_q);
    assign wrap[i] = ctrl_q[i].run && tick[i] && cnt_q[i] == pwm_timer_pkg::COUNT_TOP;
    assign cnt_nxt[i] = wrap[i] ? pwm_timer_pkg::COUNT_RESET : cnt_q[i] + 8'h01;

    // control register; reserved bits hold ones
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        ctrl_q[i] <= pwm_timer_pkg::CONTROL_RESET;
      end else if (standby) begin
        ctrl_q[i] <= pwm_timer_pkg::CONTROL_RESET;
      end else if (wr_ctrl) begin
        ctrl_q[i] <= {dat_i[7:6], pwm_timer_pkg::RESERVED_ONES, dat_i[2:0]};
      end
    end

    // counter: stopped at zero, runs 00..f9 on ticks, test write wins
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        cnt_q[i] <= pwm_timer_pkg::COUNT_RESET;
      end else if (standby || !ctrl_q[i].run) begin
        cnt_q[i] <= pwm_timer_pkg::COUNT_RESET;
      end else if (wr_cnt) begin
        cnt_q[i] <= dat_i[7:0];
      end else if (tick[i]) begin
        cnt_q[i] <= cnt_nxt[i];
      end
    end

    // duty buffer catches every write
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        buf_q[i] <= pwm_timer_pkg::DUTY_RESET;
      end else if (standby) begin
        buf_q[i] <= pwm_timer_pkg::DUTY_RESET;
      end else if (wr_duty) begin
        buf_q[i] <= dat_i[7:0];
      end
    end

    // active duty: direct while stopped, from buffer at the wrap
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        act_q[i] <= pwm_timer_pkg::DUTY_RESET;
      end else if (standby) begin
        act_q[i] <= pwm_timer_pkg::DUTY_RESET;
      end else if (!ctrl_q[i].run && wr_duty) begin
        act_q[i] <= dat_i[7:0];
      end else if (wrap[i]) begin
        act_q[i] <= buf_q[i];
      end
    end

    // logical output level
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        lvl_q[i] <= 1'b0;
      end else if (standby || !ctrl_q[i].run) begin
        lvl_q[i] <= 1'b0;
      end else if (act_q[i] == pwm_timer_pkg::DUTY_ZERO) begin
        lvl_q[i] <= 1'b0;
      end else if (act_q[i] >= pwm_timer_pkg::DUTY_FULL) begin
        lvl_q[i] <= 1'b1;
      end else if (tick[i] && !wr_cnt && cnt_nxt[i] == act_q[i]) begin
        lvl_q[i] <= 1'b0;
      end else if (tick[i] && !wr_cnt && cnt_nxt[i] == pwm_timer_pkg::COUNT_ONE) begin
        lvl_q[i] <= 1'b1;
      end
    end

    // pin stage: polarity mapping and drive enable
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        pin_q[i] <= 1'b0;
        oe_q[i] <= 1'b0;
      end else begin
        pin_q[i] <= lvl_q[i] ^ ctrl_q[i].polarity_select;
        oe_q[i] <= ctrl_q[i].run && !standby;
      end
    end

    // ----------------------------------------------------------
    // checks
    // ----------------------------------------------------------
    property p_wrap;
      @(posedge clk) disable iff (!arst_n)
      wrap[i] && !standby |=> cnt_q[i] == 8'h00;
    endproperty
    a_wrap: assert property (p_wrap) else $error("counter did not wrap to zero");

    property p_stop;
      @(posedge clk) disable iff (!arst_n)
      !ctrl_q[i].run |=> cnt_q[i] == 8'h00 && lvl_q[i] == 1'b0 && !oe_q[i];
    endproperty
    a_stop: assert property (p_stop) else $error("stopped channel still active");

    property p_zero_duty;
      @(posedge clk) disable iff (!arst_n)
      act_q[i] == 8'h00 && $stable(act_q[i]) |=> !lvl_q[i];
    endproperty
    a_zero_duty: assert property (p_zero_duty) else $error("zero duty drove output high");

    property p_full_duty;
      @(posedge clk) disable iff (!arst_n)
      ctrl_q[i].run && !standby && act_q[i] >= 8'hfa |=> lvl_q[i];
    endproperty
    a_full_duty: assert property (p_full_duty) else $error("full duty left output low");

    property p_swap;
      @(posedge clk) disable iff (!arst_n)
      wrap[i] && !standby |=> act_q[i] == $past(buf_q[i]);
    endproperty
    a_swap: assert property (p_swap) else $error("buffered duty not taken at wrap");

    property p_hold;
      @(posedge clk) disable iff (!arst_n)
      ctrl_q[i].run && !wrap[i] && !standby |=> $stable(act_q[i]);
    endproperty
    a_hold: assert property (p_hold) else $error("active duty changed mid period");

    property p_direct;
      @(posedge clk) disable iff (!arst_n)
      !ctrl_q[i].run && wr_duty && !standby |=> act_q[i] == $past(dat_i[7:0]);
    endproperty
    a_direct: assert property (p_direct) else $error("stopped duty write not immediate");

    property p_rise;
      @(posedge clk) disable iff (!arst_n)
      ctrl_q[i].run && tick[i] && cnt_q[i] == 8'h00 && !wr_cnt && !standby &&
        act_q[i] > 8'h01 && act_q[i] < 8'hfa |=> lvl_q[i];
    endproperty
    a_rise: assert property (p_rise) else $error("output not set at count one");

    property p_fall;
      @(posedge clk) disable iff (!arst_n)
      ctrl_q[i].run && tick[i] && !wr_cnt && !standby && act_q[i] != 8'h00 &&
        act_q[i] < 8'hfa && cnt_nxt[i] == act_q[i] |=> !lvl_q[i];
    endproperty
    a_fall: assert property (p_fall) else $error("output not cleared at duty");

    property p_polarity;
      @(posedge clk) disable iff (!arst_n)
      1'b1 |=> pin_q[i] == ($past(lvl_q[i]) ^ $past(ctrl_q[i].polarity_select));
    endproperty
    a_polarity: assert property (p_polarity) else $error("pin level ignores polarity");

    property p_standby;
      @(posedge clk) disable iff (!arst_n)
      standby |=> ctrl_q[i] == 8'h38 && act_q[i] == 8'hff && cnt_q[i] == 8'h00;
    endproperty
    a_standby: assert property (p_standby) else $error("standby did not initialise channel");

    property p_oe;
      @(posedge clk) disable iff (!arst_n)
      1'b1 |=> oe_q[i] == ($past(ctrl_q[i].run) && !$past(standby));
    endproperty
    a_oe: assert property (p_oe) else $error("drive enable does not follow run bit");

    property p_range;
      @(posedge clk) disable iff (!arst_n)
      ctrl_q[i].run |-> cnt_q[i] <= 8'hf9;
    endproperty
    a_range: assert property (p_range) else $error("counter left its range");

    property p_step;
      @(posedge clk) disable iff (!arst_n)
      ctrl_q[i].run && tick[i] && !wrap[i] && !wr_cnt && !standby |=>
        cnt_q[i] == $past(cnt_q[i]) + 8'h01;
    endproperty
    a_step: assert property (p_step) else $error("counter missed a source tick");

    property p_idle;
      @(posedge clk) disable iff (!arst_n)
      ctrl_q[i].run && !tick[i] && !wr_cnt && !standby |=> $stable(cnt_q[i]);
    endproperty
    a_idle: assert property (p_idle) else $error("counter moved without a source tick");
  end

  // ==========================================================
  // bus slave: one wait state, ack for one cycle
  // ==========================================================
  // read mux: duty shows the active value, control bits 5..3 read ones
  always_comb begin
    dat_d = 32'h0000_0000;
    if (req && !we_i && dec.valid) begin
      if (dec.kind == pwm_timer_pkg::REG_CONTROL) begin
        dat_d[7:0] = {ctrl_q[dec.channel].run, ctrl_q[dec.channel].polarity_select,
                      pwm_timer_pkg::RESERVED_ONES, ctrl_q[dec.channel].divider_select};
      end else if (dec.kind == pwm_timer_pkg::REG_DUTY) begin
        dat_d[7:0] = act_q[dec.channel];
      end else begin
        dat_d[7:0] = cnt_q[dec.channel];
      end
    end
  end

  // ack and read data registers; unmapped addresses ack and read zero
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= req;
      dat_q <= dat_d;
    end
  end

  property p_ack_once;
    @(posedge clk) disable iff (!arst_n)
    ack_q |=> !ack_q;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack held for two cycles");

  property p_read_ctrl;
    @(posedge clk) disable iff (!arst_n)
    req && !we_i && dec.valid && dec.kind == pwm_timer_pkg::REG_CONTROL |=>
      dat_q[5:3] == 3'h7 && dat_q[31:8] == 24'h000000;
  endproperty
  a_read_ctrl: assert property (p_read_ctrl) else $error("control read lost its fixed ones");

  // ==========================================================
  // outputs
  // ==========================================================
  assign dat_o = dat_q;
  assign ack_o = ack_q;
  assign channel_one_pin = pin_q[0];
  assign channel_one_pin_oe = oe_q[0];
  assign channel_two_pin = pin_q[1];
  assign channel_two_pin_oe = oe_q[1];
  assign channel_three_pin = pin_q[2];
  assign channel_three_pin_oe = oe_q[2];

endmodule
